// ---- rtl/icc_pkg.sv ----
// Purpose: Shared constants and types of the input capture channel
// Assumes: APB with 32-bit data, one word per register
// Notes: Control register layout sits in the low 16 bits
package icc_pkg;
	localparam logic [3:0] ICC_OFS_CTRL = 4'h0;
	localparam logic [3:0] ICC_OFS_BUF = 4'h4;
	localparam logic [3:0] ICC_OFS_STAT = 4'h8;
	localparam logic [3:0] ICC_OFS_MASK = 4'hc;
	localparam int ICC_POS_HALT = 13;
	localparam int ICC_POS_TSEL = 10;
	localparam int ICC_POS_IPER = 5;
	localparam int ICC_POS_OVF = 4;
	localparam int ICC_POS_BNE = 3;
	localparam int ICC_POS_MODE = 0;
	localparam logic [15:0] ICC_CTRL_WMASK = 16'h3c67;
	localparam logic [15:0] ICC_CTRL_RST = 16'h0000;
	localparam logic [2:0] ICC_IRQ_RST = 3'h0;
	localparam int ICC_POS_EV_CAP = 0;
	localparam int ICC_POS_EV_OVF = 1;
	localparam int ICC_POS_EV_WAKE = 2;
	localparam logic [3:0] ICC_PRE_4_LAST = 4'h3;
	localparam logic [3:0] ICC_PRE_16_LAST = 4'hf;

	typedef enum logic [2:0]
	{
		ICC_M_OFF = 3'b000,
		ICC_M_BOTH = 3'b001,
		ICC_M_FALL = 3'b010,
		ICC_M_RISE = 3'b011,
		ICC_M_PRE4 = 3'b100,
		ICC_M_PRE16 = 3'b101,
		ICC_M_UNUSED = 3'b110,
		ICC_M_WAKE = 3'b111
	} icc_mode_e;

	typedef enum logic [2:0]
	{
		ICC_T_TMR3 = 3'b000,
		ICC_T_TMR2 = 3'b001,
		ICC_T_TMR4 = 3'b010,
		ICC_T_TMR5 = 3'b011,
		ICC_T_TMR1 = 3'b100,
		ICC_T_RSV5 = 3'b101,
		ICC_T_RSV6 = 3'b110,
		ICC_T_PCLK = 3'b111
	} icc_tsel_e;

	typedef struct packed
	{
		logic [15:0] timer1_clock;
		logic [15:0] timer2_clock;
		logic [15:0] timer3_clock;
		logic [15:0] timer4_clock;
		logic [15:0] timer5_clock;
	} icc_timers_s;

	typedef struct packed
	{
		logic halt_in_idle;
		logic [2:0] timebase_select;
		logic [1:0] captures_per_irq;
		logic [2:0] capture_mode_select;
	} icc_ctrl_s;
endpackage

// ---- rtl/icc_channel.sv ----
// Purpose: Input capture channel with APB registers and capture buffer
// Assumes: Timer counts come from logic on clk_sys; capture pin is asynchronous
// Notes: Peripheral clock timebase is a free-running counter on clk_sys
//
// Contract
// - Halt bit set stops the channel in CPU idle, else it keeps running.
// - Timebase select picks peripheral clock, timer1..timer5; 110 and 101 reserved.
// - Captures-per-interrupt: interrupt every first, second, third or fourth capture.
// - Captures-per-interrupt is ignored in both-edge and wake-pin modes.
// - Read-only overflow flag sets on buffer overflow, reads zero otherwise.
// - Buffer-not-empty flag reads one while a captured value remains.
// - Overflow and not-empty bits are hardware-only, readable, reset to zero.
// - Mode 111 acts only as rising-edge wake interrupt in sleep and idle.
// - Mode 110 is unused and treated as disabled.
// - Mode 101 captures every sixteenth rising edge via a prescaler.
// - Mode 100 captures every fourth rising edge via a prescaler.
// - Mode 011 captures every rising edge.
// - Mode 010 captures every falling edge.
// - Mode 001 captures every rising and falling edge.
// - Mode 000 switches the channel off.
// - Unimplemented control bits ignore writes and read zero.
//
// Decided for this implementation: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
module icc_channel
#(
	parameter int DEPTH = 4
)
(
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic clk_en,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic capture_channel_n,
	input wire icc_pkg::icc_timers_s timers,
	input wire logic cpu_idle,
	input wire logic cpu_sleep,
	output logic irq
);
	import icc_pkg::*;

	localparam int PW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);
	localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

	// ------------------------------------------------------------
	// Registers and bus decode
	// ------------------------------------------------------------
	icc_ctrl_s ctrl;
	logic [2:0] irq_stat;
	logic [2:0] irq_mask;
	logic [15:0] pclk_count;
	logic [15:0] buf_mem [DEPTH];
	logic [PW-1:0] wr_ptr;
	logic [PW-1:0] rd_ptr;
	logic [CW-1:0] fill;
	logic ovf;
	logic sync_a;
	logic sync_b;
	logic prev_in;
	logic [3:0] pre_cnt;
	logic [1:0] ev_cnt;
	icc_mode_e mode;

	wire setup = psel && !penable;
	wire access = psel && penable && clk_en;
	wire [3:0] ofs = {paddr[3:2], 2'b00};
	wire hit_ctrl = paddr[31:4] == 28'h0 && ofs == ICC_OFS_CTRL;
	wire hit_buf = paddr[31:4] == 28'h0 && ofs == ICC_OFS_BUF;
	wire hit_stat = paddr[31:4] == 28'h0 && ofs == ICC_OFS_STAT;
	wire hit_mask = paddr[31:4] == 28'h0 && ofs == ICC_OFS_MASK;
	wire mapped = hit_ctrl || hit_buf || hit_stat || hit_mask;
	wire wr_low = access && pwrite && pstrb[0];
	wire wr_ctrl = access && pwrite && hit_ctrl && pstrb[1:0] == 2'b11;
	wire wr_stat = wr_low && hit_stat;
	wire wr_mask = wr_low && hit_mask;
	wire rd_buf = access && !pwrite && hit_buf;
	wire bne = fill != '0;
	wire full = fill == FULL_CNT;
	wire pop = rd_buf && bne;

	// Hardware-only flags are spliced in; unimplemented bits stay zero
	wire [15:0] ctrl_view = {2'b00, ctrl.halt_in_idle, ctrl.timebase_select, 3'b000,
		ctrl.captures_per_irq, ovf, bne, ctrl.capture_mode_select};

	assign mode = icc_mode_e'(ctrl.capture_mode_select);
	assign pready = clk_en;
	assign pslverr = access && !mapped;

	function automatic logic [15:0] pick_base(input logic [2:0] sel, input icc_timers_s t,
		input logic [15:0] pc);
		case (sel)
			ICC_T_PCLK: pick_base = pc;
			ICC_T_TMR1: pick_base = t.timer1_clock;
			ICC_T_TMR5: pick_base = t.timer5_clock;
			ICC_T_TMR4: pick_base = t.timer4_clock;
			ICC_T_TMR2: pick_base = t.timer2_clock;
			ICC_T_TMR3: pick_base = t.timer3_clock;
			default: pick_base = 16'h0000;
		endcase
	endfunction

	// ------------------------------------------------------------
	// Edge detection and capture qualification
	// ------------------------------------------------------------
	wire rise = sync_b && !prev_in;
	wire fall = !sync_b && prev_in;
	// Idle halt only applies when the halt bit is set
	wire halted = cpu_sleep || (ctrl.halt_in_idle && cpu_idle);
	wire active = !halted && mode != ICC_M_OFF && mode != ICC_M_UNUSED
		&& mode != ICC_M_WAKE;
	wire pre_last = (mode == ICC_M_PRE4) ? (pre_cnt == ICC_PRE_4_LAST)
		: (pre_cnt == ICC_PRE_16_LAST);
	wire pre_mode = mode == ICC_M_PRE4 || mode == ICC_M_PRE16;
	logic cap_evt;
	always_comb
	begin
		case (mode)
			ICC_M_BOTH: cap_evt = rise || fall;
			ICC_M_FALL: cap_evt = fall;
			ICC_M_RISE: cap_evt = rise;
			ICC_M_PRE4: cap_evt = rise && pre_last;
			ICC_M_PRE16: cap_evt = rise && pre_last;
			default: cap_evt = 1'b0;
		endcase
	end
	wire cap = cap_evt && active;
	wire push = cap && !full;
	wire lost = cap && full;
	wire [15:0] base = pick_base(ctrl.timebase_select, timers, pclk_count);
	// Every capture interrupts in both-edge mode
	wire irq_cap = cap && (mode == ICC_M_BOTH || ev_cnt == ctrl.captures_per_irq);
	// Wake pin ignores every other control bit
	wire irq_wake = mode == ICC_M_WAKE && rise && (cpu_sleep || cpu_idle);
	wire [2:0] ev_set = {irq_wake, lost, irq_cap};

	// ------------------------------------------------------------
	// Sequential state
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			sync_a <= 1'b0;
			sync_b <= 1'b0;
			prev_in <= 1'b0;
		end
		else if (clk_en)
		begin
			sync_a <= capture_channel_n;
			sync_b <= sync_a;
			prev_in <= sync_b;
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			ctrl <= icc_ctrl_s'(ICC_CTRL_RST);
			irq_mask <= ICC_IRQ_RST;
			pclk_count <= 16'h0000;
		end
		else if (clk_en)
		begin
			pclk_count <= pclk_count + 16'h0001;
			if (wr_ctrl)
			begin
				ctrl.halt_in_idle <= pwdata[ICC_POS_HALT];
				ctrl.timebase_select <= pwdata[ICC_POS_TSEL +: 3];
				ctrl.captures_per_irq <= pwdata[ICC_POS_IPER +: 2];
				ctrl.capture_mode_select <= pwdata[ICC_POS_MODE +: 3];
			end
			if (wr_mask)
				irq_mask <= pwdata[2:0];
		end
	end

	// Set wins over a write-one clear in the same cycle
	always_ff @(posedge clk_sys)
	begin
		if (reset)
			irq_stat <= ICC_IRQ_RST;
		else if (clk_en)
			irq_stat <= (irq_stat & ~(wr_stat ? pwdata[2:0] : 3'h0)) | ev_set;
	end

	assign irq = |(irq_stat & irq_mask);

	// Prescaler and event counters restart whenever the channel is off
	always_ff @(posedge clk_sys)
	begin
		if (reset || (clk_en && !active))
		begin
			pre_cnt <= 4'h0;
			ev_cnt <= 2'h0;
		end
		else if (clk_en)
		begin
			if (pre_mode && rise)
				pre_cnt <= pre_last ? 4'h0 : pre_cnt + 4'h1;
			if (irq_cap)
				ev_cnt <= 2'h0;
			else if (cap && mode != ICC_M_BOTH)
				ev_cnt <= ev_cnt + 2'h1;
		end
	end

	// Buffer keeps oldest values; a capture into a full buffer is dropped
	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			fill <= '0;
			ovf <= 1'b0;
		end
		else if (clk_en)
		begin
			if (push)
			begin
				buf_mem[wr_ptr] <= base;
				wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + PW'(1);
			end
			if (pop)
				rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + PW'(1);
			fill <= fill + CW'(push) - CW'(pop);
			if (lost)
				ovf <= 1'b1;
			else if (pop && fill == CW'(1))
				ovf <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (reset)
			prdata <= 32'h0000_0000;
		else if (clk_en && setup)
		begin
			if (hit_ctrl)
				prdata <= {16'h0000, ctrl_view};
			else if (hit_buf)
				prdata <= {16'h0000, bne ? buf_mem[rd_ptr] : 16'h0000};
			else if (hit_stat)
				prdata <= {29'h0, irq_stat};
			else if (hit_mask)
				prdata <= {29'h0, irq_mask};
			else
				prdata <= 32'h0000_0000;
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);

	sequence s_rise_pre4;
		clk_en && mode == ICC_M_PRE4 && active && rise;
	endsequence

	a_halt_blocks_capture: assert property (halted && clk_en |-> !push)
		else $error("capture while halted");
	a_both_ignores_count: assert property (cap && mode == ICC_M_BOTH |-> irq_cap)
		else $error("both-edge capture without event");
	a_ovf_on_full: assert property (clk_en && cap && full |=> ovf && irq_stat[ICC_POS_EV_OVF])
		else $error("overflow not flagged");
	a_bne_follows_fill: assert property (clk_en && push && !pop |=> bne && ctrl_view[3])
		else $error("not-empty flag missing");
	a_wake_no_capture: assert property (mode == ICC_M_WAKE |-> !push)
		else $error("wake mode captured");
	a_off_no_capture: assert property
		((mode == ICC_M_OFF || mode == ICC_M_UNUSED) && clk_en |=> $stable(fill) || $past(pop))
		else $error("disabled channel captured");
	a_pre4_spacing: assert property (cap && mode == ICC_M_PRE4 |-> $past(pre_cnt, 1) == 4'h3
		|| pre_cnt == ICC_PRE_4_LAST)
		else $error("prescaler spacing wrong");
	a_unimpl_zero: assert property (ctrl_view[15:14] == 2'b00 && ctrl_view[9:7] == 3'b000)
		else $error("unimplemented bits set");
	a_fall_capture: assert property (clk_en && mode == ICC_M_FALL && active && fall && !full
		|=> fill != '0)
		else $error("falling edge missed");
	a_pre4_fourth: assert property (s_rise_pre4 ##0 pre_cnt != ICC_PRE_4_LAST
		|=> pre_cnt == $past(pre_cnt) + 4'h1)
		else $error("prescaler sequence broken");
	a_pre4_wrap: assert property (s_rise_pre4 ##0 pre_cnt == ICC_PRE_4_LAST |-> cap)
		else $error("fourth edge not captured");
	a_irq_level: assert property (irq == |(irq_stat & irq_mask))
		else $error("interrupt level wrong");

	// ------------------------------------------------------------
	// Buffer, status and freeze checks
	// ------------------------------------------------------------
	sequence s_frozen;
		!clk_en;
	endsequence
	sequence s_push_only;
		clk_en && push && !pop;
	endsequence
	sequence s_pop_only;
		clk_en && pop && !push;
	endsequence
	sequence s_rise_pre16;
		clk_en && mode == ICC_M_PRE16 && active && rise;
	endsequence

	// Gated clock must not leak into any state
	a_freeze_holds: assert property (s_frozen |=> $stable(fill) && $stable(ctrl)
		&& $stable(irq_stat) && $stable(pre_cnt))
		else $error("state moved while frozen");
	a_fill_up: assert property (s_push_only |=> fill == $past(fill) + CW'(1))
		else $error("push did not count");
	a_fill_down: assert property (s_pop_only |=> fill == $past(fill) - CW'(1))
		else $error("pop did not count");
	a_fill_bound: assert property (fill <= FULL_CNT)
		else $error("fill beyond depth");
	a_empty_flag: assert property (fill == '0 |-> !ctrl_view[ICC_POS_BNE])
		else $error("not-empty flag on empty buffer");
	// Overflow only stands while old data is still waiting
	a_ovf_has_data: assert property (ovf |-> bne)
		else $error("overflow flag without data");
	a_cap_sets_stat: assert property (clk_en && irq_cap |=> irq_stat[ICC_POS_EV_CAP])
		else $error("capture event lost");
	a_cap_count: assert property (cap && mode != ICC_M_BOTH
		&& ev_cnt != ctrl.captures_per_irq |-> !irq_cap)
		else $error("interrupt before count reached");
	a_both_every: assert property (clk_en && cap && mode == ICC_M_BOTH
		|=> irq_stat[ICC_POS_EV_CAP])
		else $error("both-edge capture not flagged");
	a_wake_sets: assert property (clk_en && irq_wake |=> irq_stat[ICC_POS_EV_WAKE])
		else $error("wake event lost");
	a_wake_awake: assert property (!cpu_sleep && !cpu_idle |-> !irq_wake)
		else $error("wake event while running");
	a_rise_capture: assert property (clk_en && mode == ICC_M_RISE && active && rise
		&& !full |=> fill != '0)
		else $error("rising edge missed");
	a_rise_only: assert property (mode == ICC_M_RISE && fall |-> !cap)
		else $error("falling edge captured");
	a_fall_only: assert property (mode == ICC_M_FALL && rise |-> !cap)
		else $error("rising edge captured");
	a_off_no_irq: assert property (mode == ICC_M_OFF |-> !irq_cap && !irq_wake)
		else $error("disabled channel interrupted");
	a_unused_off: assert property (mode == ICC_M_UNUSED |-> !cap)
		else $error("unused mode captured");
	a_pre16_step: assert property (s_rise_pre16 ##0 pre_cnt != ICC_PRE_16_LAST
		|=> pre_cnt == $past(pre_cnt) + 4'h1)
		else $error("sixteen prescaler skipped");
	a_pre16_wrap: assert property (s_rise_pre16 ##0 pre_cnt == ICC_PRE_16_LAST |-> cap)
		else $error("sixteenth edge not captured");
	a_counters_idle: assert property (clk_en && !active |=> pre_cnt == 4'h0 && ev_cnt == 2'h0)
		else $error("counters kept while inactive");
	// Idle alone must not stop a channel whose halt bit is clear
	a_idle_runs: assert property (!cpu_sleep && cpu_idle && !ctrl.halt_in_idle
		&& mode == ICC_M_RISE |-> active)
		else $error("channel stopped in idle");
	// Reserved sources give a zero stamp rather than a stale timer
	a_reserved_base: assert property (ctrl.timebase_select == ICC_T_RSV5
		|| ctrl.timebase_select == ICC_T_RSV6 |-> base == 16'h0000)
		else $error("reserved timebase not zero");
	// A half-written control word must not change the mode
	a_ctrl_strobe: assert property (access && pwrite && hit_ctrl && pstrb[1:0] != 2'b11
		|=> $stable(ctrl))
		else $error("partial control write landed");
	a_ready_enable: assert property (pready == clk_en)
		else $error("ready does not follow enable");
endmodule

// ---- dv/icc_pin_model.sv ----
// Purpose: Model of the external signal on the capture pin
// Assumes: Pin idles low and changes right after rising clock edges
// Notes: Each level is held two clocks or more, the synchroniser needs that
`timescale 1ns/1ps
module icc_pin_model
(
	input wire logic clk_sys,
	output logic capture_channel_n
);
	initial capture_channel_n = 1'b0;
	// ------------
	// Pulse
	// ------------
	task automatic pulse(input int hi, input int lo);
		capture_channel_n <= 1'b1;
		repeat (hi) @(posedge clk_sys);
		capture_channel_n <= 1'b0;
		repeat (lo) @(posedge clk_sys);
	endtask
endmodule

// ---- dv/testbench.sv ----
// Purpose: Self-checking bench of the input capture channel
// Assumes: Zero-wait APB slave, capture buffer four deep
// Notes: Timer counts are random but held still, so captures are predictable
`timescale 1ns/1ps
module testbench;
	import icc_pkg::*;
	localparam logic [31:0] A_CTRL = 32'(ICC_OFS_CTRL);
	localparam logic [31:0] A_BUF = 32'(ICC_OFS_BUF);
	localparam logic [31:0] A_STAT = 32'(ICC_OFS_STAT);
	localparam logic [31:0] A_MASK = 32'(ICC_OFS_MASK);
	logic clk_sys, reset, clk_en, psel, penable, pwrite, capture_channel_n;
	logic cpu_idle, cpu_sleep, pready, pslverr, irq, err;
	logic [31:0] paddr, pwdata, prdata, rd;
	logic [3:0] pstrb;
	icc_timers_s timers;
	int n_mismatch = 0;
	int samples_checked = 0;
	int cycles = 0;
	logic [15:0] q[$];
	int ncap[7] = '{0, 32, 16, 16, 4, 1, 0};
	icc_channel #(.DEPTH(4)) i_dut (.clk_sys(clk_sys), .reset(reset), .clk_en(clk_en),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.capture_channel_n(capture_channel_n), .timers(timers), .cpu_idle(cpu_idle),
		.cpu_sleep(cpu_sleep), .irq(irq));
	icc_pin_model i_pin (.clk_sys(clk_sys), .capture_channel_n(capture_channel_n));
	// ------------
	// Clock and watchdog
	// ------------
	initial
	begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys)
	begin
		cycles <= cycles + 1;
		if (cycles == 30000)
		begin
			n_mismatch++;
			report_and_stop();
		end
	end
	// ------------
	// Tasks
	// ------------
	task automatic report_and_stop();
		$display("checked %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// Idle edge first, so back-to-back calls never drive psel twice at one edge
	task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
		int k;
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		k = 0;
		do
		begin
			@(posedge clk_sys);
			k++;
		end
		while (pready !== 1'b1 && k < 50);
		chk("pready", 32'h1, 32'(pready));
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rdc(input string nm, input logic [31:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(nm, exp, rd);
	endtask
	task automatic pulses(input int n);
		repeat (n) i_pin.pulse(4, 4);
		repeat (6) @(posedge clk_sys);
	endtask
	task automatic irq_is(input logic v);
		@(negedge clk_sys);
		chk("irq", 32'(v), 32'(irq));
	endtask
	function automatic logic [15:0] tval(input int s);
		case (s)
			0: return timers.timer3_clock;
			1: return timers.timer2_clock;
			2: return timers.timer4_clock;
			3: return timers.timer5_clock;
			4: return timers.timer1_clock;
			default: return 16'h0;
		endcase
	endfunction
	// ------------
	// Sequence
	// ------------
	initial
	begin
		int n;
		{clk_en, reset, psel, penable, pwrite, cpu_idle, cpu_sleep} = 7'h60;
		{paddr, pwdata, pstrb} = {64'h0, 4'hf};
		void'($urandom(87));
		timers = {$urandom, $urandom, 16'($urandom)};
		repeat (3) @(posedge clk_sys);
		reset <= 1'b0;
		rdc("ctrl rst", A_CTRL, 32'h0);
		rdc("stat rst", A_STAT, 32'h0);
		wr(A_CTRL, 32'hffff_ffff);
		rdc("ctrl wmask", A_CTRL, 32'h3c67);
		apb(1'b0, 32'h10, 32'h0);
		chk("unmapped", 32'h1, {rd[30:0], err});
		for (int k = 0; k < 4; k++)
		begin
			wr(A_CTRL, 32'h0);
			wr(A_STAT, 32'h7);
			wr(A_CTRL, 32'(k * 32 + 3));
			pulses(k);
			rdc("irq early", A_STAT, 32'h0);
			pulses(1);
			rdc("irq due", A_STAT, 32'h1);
			irq_is(1'b0);
			wr(A_MASK, 32'h1);
			irq_is(1'b1);
			wr(A_STAT, 32'h1);
			irq_is(1'b0);
			wr(A_MASK, 32'h0);
			for (int j = 0; j <= k; j++) rdc("buf irq", A_BUF, 32'(tval(0)));
		end
		wr(A_CTRL, 32'h0);
		wr(A_STAT, 32'h7);
		wr(A_CTRL, 32'h61);
		pulses(1);
		rdc("both ici", A_STAT, 32'h1);
		repeat (2) rdc("buf both", A_BUF, 32'(tval(0)));
		for (int m = 0; m < 7; m++)
		begin
			wr(A_CTRL, 32'h0);
			wr(A_STAT, 32'h7);
			wr(A_CTRL, 32'(m * 1024 + m));
			pulses(16);
			n = ncap[m];
			for (int j = 0; j < n && j < 4; j++) q.push_back(tval(m));
			rdc("flags", A_CTRL, 32'(m * 1024 + m + (n > 4) * 16 + (n > 0) * 8));
			rdc("events", A_STAT, 32'((n > 4) * 2 + (n > 0)));
			for (int j = 0; j < 5; j++) rdc("buf", A_BUF, 32'(q.size() ? q.pop_front() : 0));
			rdc("drained", A_CTRL, 32'(m * 1024 + m));
		end
		wr(A_CTRL, 32'h2003);
		cpu_idle <= 1'b1;
		pulses(1);
		rdc("halted", A_CTRL, 32'h2003);
		wr(A_CTRL, 32'h3);
		pulses(1);
		rdc("idle run", A_CTRL, 32'hb);
		rdc("buf idle", A_BUF, 32'(tval(0)));
		cpu_idle <= 1'b0;
		wr(A_STAT, 32'h7);
		wr(A_MASK, 32'h4);
		cpu_sleep <= 1'b1;
		wr(A_CTRL, 32'h7);
		pulses(1);
		irq_is(1'b1);
		rdc("wake flags", A_CTRL, 32'h7);
		rdc("wake ev", A_STAT, 32'h4);
		wr(A_STAT, 32'h4);
		irq_is(1'b0);
		cpu_sleep <= 1'b0;
		wr(A_CTRL, 32'h3);
		clk_en <= 1'b0;
		pulses(1);
		clk_en <= 1'b1;
		rdc("frozen", A_CTRL, 32'h3);
		pulses(1);
		rdc("run again", A_CTRL, 32'hb);
		reset <= 1'b1;
		@(posedge clk_sys);
		reset <= 1'b0;
		rdc("ctrl rerst", A_CTRL, 32'h0);
		rdc("buf rerst", A_BUF, 32'h0);
		report_and_stop();
	end
endmodule
